/* File: common/umc_pkg.sv */
`default_nettype none
package umc_pkg;
	localparam int CLK_MHZ = 100;
	// Register map and field layout
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] SYNCP_OFS = 8'h1C;
	localparam logic [31:0] CTRL_RST = 32'h00000000;
	localparam logic [31:0] CTRL_WMASK = 32'h7FF3E19E;
	localparam logic [31:0] EN_MASK = 32'h00000002;
	localparam int B_SOFT_RESET_BIT = 0;
	localparam int B_EN = 1;
	localparam int B_MODE = 2;
	localparam int B_STBY = 7;
	localparam int B_IMMEDIATE_OVERFLOW_NOTIFY = 8;
	localparam int B_OVERSAMPLE_RATE = 13;
	localparam int B_TX_PAD_SELECT = 16;
	localparam int B_RX_PAD_SELECT = 20;
	localparam int B_SAMPLE_ADJUST = 22;
	localparam int B_FORM = 24;
	localparam int B_SYNC_ASYNC_SELECT = 28;
	localparam int B_CLOCK_EDGE_SELECT = 29;
	localparam int B_BIT_ORDER = 30;
	// Field codes
	localparam logic [3:0] FORM_PAR = 4'h1;
	localparam logic [3:0] FORM_BRKPAR = 4'h5;
	localparam logic [2:0] MODE_EXT = 3'h0;
	localparam logic [2:0] MODE_INT = 3'h1;
	localparam logic [2:0] SR_8A = 3'h2;
	localparam logic [2:0] SR_8F = 3'h3;
	localparam logic [2:0] SR_3A = 3'h4;
	localparam logic [3:0] OS_LAST_16 = 4'hF;
	localparam logic [3:0] OS_LAST_8 = 4'h7;
	localparam logic [3:0] OS_LAST_3 = 4'h2;
	localparam logic [3:0] POS_16 = 4'h7;
	localparam logic [3:0] POS_8 = 4'h3;
	localparam logic [1:0] TX_PAD_SELECT_P0 = 2'h0;
	localparam logic [1:0] TX_PAD_SELECT_P2 = 2'h1;
	localparam logic [1:0] TX_PAD_SELECT_FLOW = 2'h2;
	// Frame bit indices: 0 start, 1..8 data, then parity and stop
	localparam logic [3:0] IDX_STOP_NP = 4'h9;
	localparam logic [3:0] IDX_STOP_P = 4'hA;
	localparam logic [3:0] TX_BITS_NP = 4'hA;
	localparam logic [3:0] TX_BITS_P = 4'hB;
	// Timing
	localparam int SYNC_NS = 30;
	localparam logic [3:0] SYNC_CYC = 4'((SYNC_NS * CLK_MHZ + 999) / 1000);
	localparam int TICK_NS = 100;
	localparam logic [7:0] TICK_CYC = 8'(TICK_NS * CLK_MHZ / 1000);
	localparam int XCK_HALF_NS = 500;
	localparam logic [7:0] XCK_HALF_CYC = 8'(XCK_HALF_NS * CLK_MHZ / 1000);
	typedef enum logic [1:0] {
		UMC_RX_IDLE = 2'b01,
		UMC_RX_BITS = 2'b10
	} umc_rx_t;
endpackage : umc_pkg
`default_nettype wire

/* File: logic/umc_usart_ctrl.sv */
// Functional notes
// - Atomic 8, 16, 32-bit register accesses
// - Each byte or half accessible alone
// - Enable-protected fields writable only when disabled
// - Write-protected registers lockable by access guard
// - Reserved bits read zero, written zero
// - Bit 30 selects MSB or LSB first
// - Bit 29 swaps change and sample edges
// - Bit 28 selects async or sync mode
// - Frame format: plain, parity, break variants
// - Sample adjust picks three voted ticks at 16x and 8x
// - Receive data taken from selected pad
// - Transmit pad, clock and flow-control routing
// - Oversample rate 16x, 8x or 3x
// - Overflow flag in-stream or immediate
// - No standby run, external: drop reception
// - No standby run, internal: stop generic clock
// - Standby run, external: wake on receive
// - Standby run, internal: clock on, any wake
// - Mode field selects external or internal clock
// - Soft reset clears all, discards same write
// - Sync pending set; repeat while set errors
// - Enable reads back at once, acts later
`timescale 1ns/1ps
`default_nettype none
module umc_usart_ctrl (
	input wire logic core_clk, // System clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic psel, // Register port select
	input wire logic penable, // Register port access phase
	input wire logic pwrite, // Write access
	input wire logic [7:0] paddr, // Byte address
	input wire logic [31:0] pwdata, // Write data
	input wire logic [3:0] pstrb, // Byte lane strobes
	output logic [31:0] prdata, // Read data
	output logic pready, // Access complete
	output logic pslverr, // Bus error
	input wire logic wp_lock, // Access guard write lock
	input wire logic standby, // System in standby sleep
	input wire logic [3:0] pad_in, // Pad levels from pins
	output logic [3:0] pad_out, // Pad drive values
	output logic [3:0] pad_oe, // Pad output enables
	input wire logic [7:0] tx_data, // Word to send
	input wire logic tx_valid, // Word to send is valid
	output logic tx_ready, // Transmitter takes word
	output logic [7:0] rx_data, // Received word
	output logic rx_valid, // Received word valid
	input wire logic rx_ready, // Consumer takes word
	output logic overflow_flag, // Receive buffer overflow
	input wire logic overflow_clr, // Clear overflow flag
	output logic gclk_run, // Generic clock request
	output logic wake // Wake request pulse
);
	////////////////////////////////////////////////////////////////////////
	logic [31:0] ctrl_ff, nxt_ctrl_ff;
	logic swp_ff, nxt_swp_ff, enp_ff, nxt_enp_ff;
	logic unit_on_ff, nxt_unit_on_ff;
	logic [3:0] sync_cnt_ff, nxt_sync_cnt_ff;
	logic [31:0] bmask, upd;
	logic acc_wr, bus_err, ctrl_wr, sw_wr, en_wr;
	logic sync_mode, int_clk, immediate_overflow_notify, stby_run, bit_order, clock_edge_select, has_par;
	logic [3:0] form;
	logic [2:0] oversample_rate;
	logic [1:0] tx_pad_select, rx_pad_select, sample_adjust;
	logic dp_rst;

	assign bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
		{8{pstrb[0]}}};
	assign acc_wr = psel & penable & pwrite;
	assign bus_err = acc_wr & (wp_lock | swp_ff
		| (paddr == umc_pkg::CTRL_OFS & pstrb[0] & enp_ff));
	assign ctrl_wr = acc_wr & ~bus_err & (paddr == umc_pkg::CTRL_OFS);
	assign sw_wr = ctrl_wr & pstrb[0] & pwdata[umc_pkg::B_SOFT_RESET_BIT];
	assign en_wr = ctrl_wr & pstrb[0] & ~sw_wr;
	assign pready = 1'b1;
	assign pslverr = bus_err;
	assign dp_rst = rst | swp_ff;

	always_comb begin
		nxt_ctrl_ff = ctrl_ff;
		nxt_swp_ff = swp_ff;
		nxt_enp_ff = enp_ff;
		nxt_unit_on_ff = unit_on_ff;
		nxt_sync_cnt_ff = sync_cnt_ff;
		upd = ctrl_ff[umc_pkg::B_EN] ? umc_pkg::EN_MASK
			: umc_pkg::CTRL_WMASK;
		if (sync_cnt_ff != 4'h0) begin
			nxt_sync_cnt_ff = sync_cnt_ff - 4'h1;
			if (sync_cnt_ff == 4'h1) begin
				nxt_swp_ff = 1'b0;
				nxt_enp_ff = 1'b0;
				nxt_unit_on_ff = ctrl_ff[umc_pkg::B_EN] & ~swp_ff;
			end
		end
		if (sw_wr) begin
			nxt_ctrl_ff = umc_pkg::CTRL_RST;
			nxt_swp_ff = 1'b1;
			nxt_enp_ff = 1'b0;
			nxt_unit_on_ff = 1'b0;
			nxt_sync_cnt_ff = umc_pkg::SYNC_CYC;
		end else if (ctrl_wr) begin
			nxt_ctrl_ff = (ctrl_ff & ~(upd & bmask))
				| (pwdata & upd & bmask);
			if (en_wr) begin
				nxt_enp_ff = 1'b1;
				nxt_sync_cnt_ff = umc_pkg::SYNC_CYC;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_ff <= umc_pkg::CTRL_RST;
			swp_ff <= 1'b0;
			enp_ff <= 1'b0;
			unit_on_ff <= 1'b0;
			sync_cnt_ff <= 4'h0;
		end else begin
			ctrl_ff <= nxt_ctrl_ff;
			swp_ff <= nxt_swp_ff;
			enp_ff <= nxt_enp_ff;
			unit_on_ff <= nxt_unit_on_ff;
			sync_cnt_ff <= nxt_sync_cnt_ff;
		end
	end

	always_comb begin
		if (paddr == umc_pkg::CTRL_OFS)
			prdata = ctrl_ff | {31'h0, swp_ff};
		else if (paddr == umc_pkg::SYNCP_OFS)
			prdata = {30'h0, enp_ff, swp_ff};
		else
			prdata = 32'h00000000;
	end

	assign bit_order = ctrl_ff[umc_pkg::B_BIT_ORDER];
	assign clock_edge_select = ctrl_ff[umc_pkg::B_CLOCK_EDGE_SELECT];
	assign sync_mode = ctrl_ff[umc_pkg::B_SYNC_ASYNC_SELECT];
	assign form = ctrl_ff[umc_pkg::B_FORM +: 4];
	assign has_par = (form == umc_pkg::FORM_PAR)
		| (form == umc_pkg::FORM_BRKPAR);
	assign sample_adjust = ctrl_ff[umc_pkg::B_SAMPLE_ADJUST +: 2];
	assign rx_pad_select = ctrl_ff[umc_pkg::B_RX_PAD_SELECT +: 2];
	assign tx_pad_select = ctrl_ff[umc_pkg::B_TX_PAD_SELECT +: 2];
	assign oversample_rate = ctrl_ff[umc_pkg::B_OVERSAMPLE_RATE +: 3];
	assign immediate_overflow_notify = ctrl_ff[umc_pkg::B_IMMEDIATE_OVERFLOW_NOTIFY];
	assign stby_run = ctrl_ff[umc_pkg::B_STBY];
	assign int_clk = ctrl_ff[umc_pkg::B_MODE +: 3] == umc_pkg::MODE_INT;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers, serial clock and oversample tick
	logic [3:0] pad_s1_ff, pad_s2_ff;
	logic xck_ff, nxt_xck_ff, xck_prev_ff, xck_cur;
	logic [7:0] xdiv_ff, nxt_xdiv_ff, tick_cnt_ff, nxt_tick_cnt_ff;
	logic tick, rise, fall, chg_edge, samp_edge, link_on, busy;
	logic rx_in, cts_stop;
	logic [3:0] os_last, pos0;

	assign rx_in = pad_s2_ff[rx_pad_select];
	assign cts_stop = (tx_pad_select == umc_pkg::TX_PAD_SELECT_FLOW) & pad_s2_ff[3];
	assign xck_cur = int_clk ? xck_ff
		: (tx_pad_select == umc_pkg::TX_PAD_SELECT_P2 ? pad_s2_ff[3] : pad_s2_ff[1]);
	assign rise = xck_cur & ~xck_prev_ff;
	assign fall = ~xck_cur & xck_prev_ff;
	// External clock is cut in standby once idle unless standby run is set; reception dropped
	assign link_on = int_clk | ~standby | stby_run | busy;
	assign chg_edge = sync_mode & link_on & (clock_edge_select ? fall : rise);
	assign samp_edge = sync_mode & link_on & (clock_edge_select ? rise : fall);
	assign tick = unit_on_ff & (tick_cnt_ff == 8'h00);

	always_comb begin
		case (oversample_rate)
			umc_pkg::SR_8A, umc_pkg::SR_8F: begin
				os_last = umc_pkg::OS_LAST_8;
				pos0 = umc_pkg::POS_8 + {2'h0, sample_adjust};
			end
			umc_pkg::SR_3A: begin
				os_last = umc_pkg::OS_LAST_3;
				pos0 = 4'h1;
			end
			default: begin
				os_last = umc_pkg::OS_LAST_16;
				pos0 = umc_pkg::POS_16 + {1'h0, sample_adjust, 1'b0};
			end
		endcase
		nxt_tick_cnt_ff = (tick_cnt_ff == 8'h00)
			? umc_pkg::TICK_CYC - 8'h01 : tick_cnt_ff - 8'h01;
		nxt_xdiv_ff = xdiv_ff;
		nxt_xck_ff = xck_ff;
		if (unit_on_ff & sync_mode & int_clk) begin
			nxt_xdiv_ff = xdiv_ff + 8'h01;
			if (xdiv_ff == umc_pkg::XCK_HALF_CYC - 8'h01) begin
				nxt_xdiv_ff = 8'h00;
				nxt_xck_ff = ~xck_ff;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (dp_rst) begin
			pad_s1_ff <= 4'hF;
			pad_s2_ff <= 4'hF;
			xck_ff <= 1'b0;
			xck_prev_ff <= 1'b0;
			xdiv_ff <= 8'h00;
			tick_cnt_ff <= 8'h00;
		end else begin
			pad_s1_ff <= pad_in;
			pad_s2_ff <= pad_s1_ff;
			xck_ff <= nxt_xck_ff;
			xck_prev_ff <= xck_cur;
			xdiv_ff <= nxt_xdiv_ff;
			tick_cnt_ff <= nxt_tick_cnt_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receiver
	umc_pkg::umc_rx_t rx_st_ff, nxt_rx_st_ff;
	logic [3:0] rx_os_ff, nxt_rx_os_ff, rx_idx_ff, nxt_rx_idx_ff;
	logic [2:0] vote_ff, nxt_vote_ff;
	logic [7:0] rx_sh_ff, nxt_rx_sh_ff;
	logic rx_px_ff, nxt_rx_px_ff, maj, bit_done, bit_val;
	logic rx_push, rx_start_ev, vote_now;
	logic [3:0] os_num;

	// Ticks are numbered from one within a bit
	assign os_num = rx_os_ff + 4'h1;
	// Third sample may land on the bit's last tick, so it is voted live
	assign vote_now = (~sync_mode & tick & (os_num == pos0 + 4'h2))
		? rx_in : vote_ff[2];
	assign maj = (vote_ff[0] & vote_ff[1]) | (vote_ff[0] & vote_now)
		| (vote_ff[1] & vote_now);
	assign bit_done = sync_mode ? samp_edge : (tick & rx_os_ff == os_last);
	assign bit_val = sync_mode ? rx_in : maj;

	always_comb begin
		nxt_rx_st_ff = rx_st_ff;
		nxt_rx_os_ff = rx_os_ff;
		nxt_rx_idx_ff = rx_idx_ff;
		nxt_vote_ff = vote_ff;
		nxt_rx_sh_ff = rx_sh_ff;
		nxt_rx_px_ff = rx_px_ff;
		rx_push = 1'b0;
		rx_start_ev = 1'b0;
		if (~unit_on_ff | ~link_on) begin
			nxt_rx_st_ff = umc_pkg::UMC_RX_IDLE;
		end else begin
			case (rx_st_ff)
				umc_pkg::UMC_RX_IDLE: begin
					if (~rx_in & (sync_mode ? samp_edge : tick)) begin
						nxt_rx_st_ff = umc_pkg::UMC_RX_BITS;
						nxt_rx_idx_ff = sync_mode ? 4'h1 : 4'h0;
						nxt_rx_os_ff = 4'h1;
						nxt_vote_ff = 3'h0;
						nxt_rx_px_ff = 1'b0;
						rx_start_ev = 1'b1;
					end
				end
				umc_pkg::UMC_RX_BITS: begin
					if (~sync_mode & tick) begin
						nxt_rx_os_ff = (rx_os_ff == os_last) ? 4'h0
							: rx_os_ff + 4'h1;
						if (os_num == pos0)
							nxt_vote_ff[0] = rx_in;
						if (os_num == pos0 + 4'h1)
							nxt_vote_ff[1] = rx_in;
						if (os_num == pos0 + 4'h2)
							nxt_vote_ff[2] = rx_in;
					end
					if (bit_done) begin
						nxt_rx_idx_ff = rx_idx_ff + 4'h1;
						if (rx_idx_ff == 4'h0) begin
							if (bit_val)
								nxt_rx_st_ff = umc_pkg::UMC_RX_IDLE;
						end else if (rx_idx_ff <= 4'h8) begin
							nxt_rx_sh_ff = bit_order ? {bit_val, rx_sh_ff[7:1]}
								: {rx_sh_ff[6:0], bit_val};
							nxt_rx_px_ff = rx_px_ff ^ bit_val;
						end else if (rx_idx_ff == (has_par
							? umc_pkg::IDX_STOP_P : umc_pkg::IDX_STOP_NP)) begin
							nxt_rx_st_ff = umc_pkg::UMC_RX_IDLE;
							rx_push = bit_val & ~(has_par & rx_px_ff);
						end else begin
							nxt_rx_px_ff = rx_px_ff ^ bit_val;
						end
					end
				end
				default: nxt_rx_st_ff = umc_pkg::UMC_RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (dp_rst) begin
			rx_st_ff <= umc_pkg::UMC_RX_IDLE;
			rx_os_ff <= 4'h0;
			rx_idx_ff <= 4'h0;
			vote_ff <= 3'h0;
			rx_sh_ff <= 8'h00;
			rx_px_ff <= 1'b0;
		end else begin
			rx_st_ff <= nxt_rx_st_ff;
			rx_os_ff <= nxt_rx_os_ff;
			rx_idx_ff <= nxt_rx_idx_ff;
			vote_ff <= nxt_vote_ff;
			rx_sh_ff <= nxt_rx_sh_ff;
			rx_px_ff <= nxt_rx_px_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Two-entry receive buffer and overflow notification
	logic [7:0] buf_ff [2];
	logic [7:0] nxt_buf_ff [2];
	logic wp_ff, nxt_wp_ff, rp_ff, nxt_rp_ff;
	logic [1:0] cnt_ff, nxt_cnt_ff;
	logic ovf_ff, nxt_ovf_ff, ovp_ff, nxt_ovp_ff, pop, do_push, ovf_ev;

	assign rx_valid = cnt_ff != 2'h0;
	assign rx_data = buf_ff[rp_ff];
	assign pop = rx_valid & rx_ready;
	assign do_push = rx_push & ((cnt_ff != 2'h2) | pop);
	assign ovf_ev = rx_push & ~do_push;
	assign overflow_flag = ovf_ff;

	always_comb begin
		nxt_buf_ff = buf_ff;
		nxt_wp_ff = wp_ff ^ do_push;
		nxt_rp_ff = rp_ff ^ pop;
		nxt_cnt_ff = cnt_ff + {1'b0, do_push} - {1'b0, pop};
		if (do_push)
			nxt_buf_ff[wp_ff] = rx_sh_ff;
		nxt_ovp_ff = (ovp_ff & ~pop) | (ovf_ev & ~immediate_overflow_notify);
		// Setting wins over a clear in the same cycle
		nxt_ovf_ff = (ovf_ff & ~overflow_clr) | (ovf_ev & immediate_overflow_notify)
			| (ovp_ff & pop);
	end

	always_ff @(posedge core_clk) begin
		if (dp_rst) begin
			buf_ff[0] <= 8'h00;
			buf_ff[1] <= 8'h00;
			wp_ff <= 1'b0;
			rp_ff <= 1'b0;
			cnt_ff <= 2'h0;
			ovf_ff <= 1'b0;
			ovp_ff <= 1'b0;
		end else begin
			buf_ff <= nxt_buf_ff;
			wp_ff <= nxt_wp_ff;
			rp_ff <= nxt_rp_ff;
			cnt_ff <= nxt_cnt_ff;
			ovf_ff <= nxt_ovf_ff;
			ovp_ff <= nxt_ovp_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmitter, pins and standby
	logic [10:0] tx_fr_ff, nxt_tx_fr_ff;
	logic [3:0] tx_left_ff, nxt_tx_left_ff, tx_os_ff, nxt_tx_os_ff;
	logic tx_step, tx_done_ev, txd, any_ev;
	logic [7:0] tx_rev;
	logic [3:0] nxt_pad_out, nxt_pad_oe;
	logic nxt_gclk_run, nxt_wake;

	assign tx_ready = unit_on_ff & (tx_left_ff == 4'h0) & ~cts_stop;
	assign tx_step = sync_mode ? chg_edge : (tick & tx_os_ff == os_last);
	assign tx_done_ev = tx_step & (tx_left_ff == 4'h1);
	assign busy = (rx_st_ff == umc_pkg::UMC_RX_BITS) | (tx_left_ff != 4'h0);
	assign txd = (tx_left_ff != 4'h0) ? tx_fr_ff[0] : 1'b1;
	assign any_ev = rx_start_ev | rx_push | tx_done_ev | ovf_ev;

	for (genvar gi = 0; gi < 8; gi++) begin : g_rev
		assign tx_rev[gi] = tx_data[7 - gi];
	end

	always_comb begin
		nxt_tx_fr_ff = tx_fr_ff;
		nxt_tx_left_ff = tx_left_ff;
		nxt_tx_os_ff = tx_os_ff;
		if (~unit_on_ff) begin
			nxt_tx_left_ff = 4'h0;
		end else if (tx_valid & tx_ready) begin
			nxt_tx_fr_ff = {1'b1, has_par ? ^tx_data : 1'b1,
				bit_order ? tx_data : tx_rev, 1'b0};
			nxt_tx_left_ff = has_par ? umc_pkg::TX_BITS_P
				: umc_pkg::TX_BITS_NP;
			nxt_tx_os_ff = 4'h0;
		end else if (tx_left_ff != 4'h0) begin
			if (tick)
				nxt_tx_os_ff = (tx_os_ff == os_last) ? 4'h0
					: tx_os_ff + 4'h1;
			if (tx_step) begin
				nxt_tx_fr_ff = {1'b1, tx_fr_ff[10:1]};
				nxt_tx_left_ff = tx_left_ff - 4'h1;
			end
		end
		nxt_pad_out = 4'h0;
		nxt_pad_oe = 4'h0;
		if (unit_on_ff) begin
			case (tx_pad_select)
				umc_pkg::TX_PAD_SELECT_P0: begin
					nxt_pad_out = {2'h0, xck_ff, txd};
					nxt_pad_oe = {2'h0, sync_mode & int_clk, 1'b1};
				end
				umc_pkg::TX_PAD_SELECT_P2: begin
					nxt_pad_out = {xck_ff, txd, 2'h0};
					nxt_pad_oe = {sync_mode & int_clk, 1'b1, 2'h0};
				end
				umc_pkg::TX_PAD_SELECT_FLOW: begin
					nxt_pad_out = {1'b0, cnt_ff == 2'h2, 1'b0, txd};
					nxt_pad_oe = 4'h5;
				end
				default: begin
					nxt_pad_out = 4'h0;
					nxt_pad_oe = 4'h0;
				end
			endcase
		end
		nxt_gclk_run = unit_on_ff & (~int_clk | ~standby | stby_run
			| busy);
		if (int_clk)
			nxt_wake = standby & (stby_run ? any_ev
				: (rx_start_ev | tx_done_ev));
		else
			nxt_wake = standby & stby_run & (rx_start_ev | rx_push);
	end

	always_ff @(posedge core_clk) begin
		if (dp_rst) begin
			tx_fr_ff <= 11'h7FF;
			tx_left_ff <= 4'h0;
			tx_os_ff <= 4'h0;
			pad_out <= 4'h0;
			pad_oe <= 4'h0;
			gclk_run <= 1'b0;
			wake <= 1'b0;
		end else begin
			tx_fr_ff <= nxt_tx_fr_ff;
			tx_left_ff <= nxt_tx_left_ff;
			tx_os_ff <= nxt_tx_os_ff;
			pad_out <= nxt_pad_out;
			pad_oe <= nxt_pad_oe;
			gclk_run <= nxt_gclk_run;
			wake <= nxt_wake;
		end
	end

	////////////////////////////////////////////////////////////////////////
	AST_WP_LOCK: assert property (@(posedge core_clk) disable iff (rst)
		acc_wr && wp_lock |-> pslverr ##1 $stable(ctrl_ff))
		else $error("locked write was not refused");
	AST_EN_SEQ: assert property (@(posedge core_clk) disable iff (rst)
		en_wr && pwdata[1] && !unit_on_ff && !enp_ff
		|=> ctrl_ff[1] && enp_ff ##3 unit_on_ff && !enp_ff)
		else $error("enable did not read back then take effect");
	AST_SYNC_ERR: assert property (@(posedge core_clk) disable iff (rst)
		acc_wr && paddr == 8'h00 && pstrb[0] && enp_ff |-> pslverr)
		else $error("write during pending sync not refused");
	AST_PROT: assert property (@(posedge core_clk) disable iff (rst)
		ctrl_wr && !sw_wr && ctrl_ff[1]
		|=> (ctrl_ff & 32'h7FF3E19C) == $past(ctrl_ff & 32'h7FF3E19C))
		else $error("protected field changed while enabled");
	AST_RSVD: assert property (@(posedge core_clk) disable iff (rst)
		paddr == 8'h00 |-> (prdata & 32'h800C1E60) == 32'h0)
		else $error("reserved bit reads nonzero");
	AST_SOFT_RESET_BIT: assert property (@(posedge core_clk) disable iff (rst)
		sw_wr |=> ctrl_ff == 32'h0 && swp_ff && !unit_on_ff ##3 !swp_ff)
		else $error("soft reset sequence wrong");
	AST_OVF_IMM: assert property (@(posedge core_clk) disable iff (rst)
		ovf_ev && immediate_overflow_notify && !swp_ff |=> overflow_flag)
		else $error("immediate overflow not flagged");
	AST_RTS: assert property (@(posedge core_clk) disable iff (rst)
		unit_on_ff && tx_pad_select == 2'h2 && cnt_ff == 2'h2 && !swp_ff
		|=> pad_oe[2] && pad_out[2])
		else $error("flow-control stop not driven");
endmodule : umc_usart_ctrl
`default_nettype wire

/* File: bench/umc_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module umc_peer #(
	parameter int BIT_NS = 1600
) (
	output logic line_out, // Data toward the unit
	input wire logic line_in // Data from the unit
);
	// Idle async line marks high
	initial line_out = 1'b1;

	task automatic send(input logic [7:0] d, input bit lsb, input bit par);
		int i;
		line_out = 1'b0;
		#(BIT_NS);
		for (i = 0; i < 8; i++) begin
			line_out = lsb ? d[i] : d[7 - i];
			#(BIT_NS);
		end
		// Even parity over the data bits
		if (par) begin
			line_out = ^d;
			#(BIT_NS);
		end
		line_out = 1'b1;
		#(BIT_NS);
	endtask : send

	task automatic take(output logic [7:0] d, input bit lsb);
		int i;
		@(negedge line_in);
		#(BIT_NS * 3 / 2);
		for (i = 0; i < 8; i++) begin
			d[lsb ? i : 7 - i] = line_in;
			#(BIT_NS);
		end
	endtask : take
endmodule : umc_peer
`default_nettype wire

/* File: bench/usart_primary_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module usart_primary_control_bench;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'h0;
	logic wp_lock = 1'b0;
	logic standby = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_valid = 1'b0;
	logic rx_ready = 1'b0;
	logic overflow_clr = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, tx_ready, rx_valid, overflow_flag, gclk_run;
	logic [3:0] pad_in, pad_out, pad_oe;
	logic [7:0] rx_data;
	logic rx_line, tx_line, wake;
	logic cts_line = 1'b0;
	int wakes = 0;
	int failures = 0;
	int checks_done = 0;
	logic [31:0] seed = 32'h00013040;
	logic [7:0] rxq[$];

	always #5 core_clk = ~core_clk;
	// Undriven pads are pulled high
	assign tx_line = pad_oe[0] ? pad_out[0] : 1'b1;
	assign pad_in = {cts_line, 1'b1, rx_line, tx_line};

	always @(posedge core_clk) begin
		if (wake === 1'b1)
			wakes++;
	end

	umc_usart_ctrl dut (.core_clk(core_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.wp_lock(wp_lock), .standby(standby), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe(pad_oe), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready),
		.overflow_flag(overflow_flag), .overflow_clr(overflow_clr),
		.gclk_run(gclk_run), .wake(wake));
	umc_peer peer (.line_out(rx_line), .line_in(tx_line));

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic end_sim();
		$display("Counts: %0d checks, %0d failures", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim

	task automatic idle(input int n);
		repeat (n) @(negedge core_clk);
	endtask : idle

	// One register access, held until the answering edge
	task automatic bus(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic w, output logic [31:0] r,
		output logic e);
		@(negedge core_clk);
		psel = 1'b1;
		pwrite = w;
		paddr = a;
		pwdata = d;
		pstrb = s;
		@(negedge core_clk);
		penable = 1'b1;
		@(posedge core_clk);
		r = prdata;
		e = pslverr;
		chk({31'h0, pready}, 32'h1, "ready");
		@(negedge core_clk);
		psel = 1'b0;
		penable = 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic e);
		logic [31:0] r;
		logic err;
		bus(a, d, s, 1'b1, r, err);
		chk({31'h0, err}, {31'h0, e}, "write response");
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic err;
		bus(a, 32'h00000000, 4'h0, 1'b0, r, err);
		chk(r, exp, "register read");
	endtask : rd

	////////////////////////////////////////////////////////////////////////
	initial begin
		#400_000;
		failures++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_sim();
	end

	initial begin
		logic [31:0] cfg;
		logic [7:0] b, got;
		bit lsb;
		int p, k, n;
		repeat (10) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		rd(8'h00, 32'h00000000);
		rd(8'h1C, 32'h00000000);
		rd(8'h40, 32'h00000000);
		$display("test reset values done");
		wp_lock = 1'b1;
		wr(8'h00, 32'h00000080, 4'hF, 1'b1);
		wp_lock = 1'b0;
		rd(8'h00, 32'h00000000);
		$display("test lock done");
		wr(8'h00, 32'h7FF3E19C, 4'h4, 1'b0);
		rd(8'h00, 32'h00F30000);
		wr(8'h00, 32'h7FF3E19C, 4'hF, 1'b0);
		rd(8'h00, 32'h7FF3E19C);
		$display("test lanes done");
		wr(8'h00, 32'h7FF3E19E, 4'h1, 1'b0);
		wr(8'h00, 32'h7FF3E19E, 4'h1, 1'b1);
		rd(8'h00, 32'h7FF3E19E);
		rd(8'h1C, 32'h00000000);
		wr(8'h00, 32'h00000000, 4'hE, 1'b0);
		rd(8'h00, 32'h7FF3E19E);
		$display("test enable done");
		wr(8'h00, 32'h7FF3E19C, 4'h1, 1'b0);
		idle(5);
		wr(8'h00, 32'h00000081, 4'h1, 1'b0);
		wr(8'h00, 32'h00000080, 4'h1, 1'b1);
		idle(6);
		rd(8'h00, 32'h00000000);
		rd(8'h1C, 32'h00000000);
		$display("test soft reset done");
		for (p = 0; p < 2; p++) begin
			lsb = (p == 0);
			// Internal clock, receive on pad 1, 16x; pass 0 LSB first,
			// standby run, immediate overflow; pass 1 parity, flow control
			cfg = lsb ? 32'h40100184 : 32'h01120004;
			wr(8'h00, 32'h00000000, 4'h1, 1'b0);
			idle(5);
			wr(8'h00, cfg, 4'hF, 1'b0);
			rd(8'h00, cfg);
			wr(8'h00, cfg | 32'h00000002, 4'h1, 1'b0);
			idle(5);
			standby = 1'b1;
			idle(5);
			chk({31'h0, gclk_run}, {31'h0, lsb}, "clock in standby");
			n = wakes;
			for (k = 0; k < 3; k++) begin
				b = 8'(xs());
				if (k < 2) rxq.push_back(b);
				peer.send(b, lsb, !lsb);
			end
			standby = 1'b0;
			chk({31'h0, wakes > n}, 32'h1, "wake in standby");
			idle(5);
			chk({31'h0, overflow_flag}, {31'h0, lsb}, "overflow early");
			chk({31'h0, pad_oe[2] & pad_out[2]}, {31'h0, !lsb}, "rts");
			for (k = 0; k < 2; k++) begin
				@(negedge core_clk);
				rx_ready = 1'b1;
				@(posedge core_clk);
				chk({31'h0, rx_valid}, 32'h1, "rx valid");
				chk({24'h0, rx_data}, {24'h0, rxq.pop_front()}, "rx word");
				@(negedge core_clk);
				rx_ready = 1'b0;
			end
			idle(2);
			chk({31'h0, rx_valid}, 32'h0, "rx empty");
			chk({31'h0, overflow_flag}, 32'h1, "overflow late");
			overflow_clr = 1'b1;
			idle(1);
			overflow_clr = 1'b0;
			idle(2);
			chk({31'h0, overflow_flag}, 32'h0, "overflow cleared");
			cts_line = 1'b1;
			idle(4);
			chk({31'h0, tx_ready}, {31'h0, lsb}, "cts stall");
			cts_line = 1'b0;
			idle(4);
			b = 8'(xs());
			n = 0;
			fork
				peer.take(got, lsb);
				begin
					@(negedge core_clk);
					tx_data = b;
					tx_valid = 1'b1;
					@(posedge core_clk);
					while (tx_ready !== 1'b1 && n < 200) begin
						n++;
						@(posedge core_clk);
					end
					@(negedge core_clk);
					tx_valid = 1'b0;
				end
			join
			chk({24'h0, got}, {24'h0, b}, "tx word");
			$display("test traffic pass %0d done", p);
		end
		end_sim();
	end
endmodule : usart_primary_control_bench
`default_nettype wire
